// ==== rtl/fpa_map.svh ====
// Offsets, field positions, opcode codes and timing counts for the float accelerator port.
// Assumes the including file needs no further definitions.
`ifndef FPA_MAP_SVH
`define FPA_MAP_SVH
// Shared microcycle and core clock period.
`define MICROCYCLE_NS 200
`define CLK_PERIOD_PS 4000
`define MICROCYCLE_CYCLES ((`MICROCYCLE_NS * 1000) / `CLK_PERIOD_PS)
// Opcode codes; bit zero marks double precision.
`define OP_ADD_SINGLE 4'h0
`define OP_ADD_DOUBLE 4'h1
`define OP_SUB_SINGLE 4'h2
`define OP_SUB_DOUBLE 4'h3
`define OP_MUL_SINGLE 4'h4
`define OP_MUL_DOUBLE 4'h5
`define OP_DIV_SINGLE 4'h6
`define OP_DIV_DOUBLE 4'h7
`define OP_POLY_SINGLE 4'h8
`define OP_POLY_DOUBLE 4'h9
`define OP_EMOD_SINGLE 4'ha
`define OP_EMOD_DOUBLE 4'hb
`define OP_INT_MUL 4'hc
// Operation classes, taken from opcode bits 3 to 1.
`define CLS_ADD 3'h0
`define CLS_SUB 3'h1
`define CLS_MUL 3'h2
`define CLS_DIV 3'h3
`define CLS_POLY 3'h4
`define CLS_EMOD 3'h5
`define CLS_INT_MUL 3'h6
// Excess-128 exponent limits.
`define EXP_BIAS 10'h080
`define EXP_MAX 10'h0ff
`define EXP_MIN 10'h001
// Packed word fields.
`define SIGN_BIT 63
`define EXP_MSB 62
`define EXP_LSB 55
// Self-test operand (one half) and expected square (one quarter).
`define DIAG_OPERAND 64'h4000000000000000
`define DIAG_EXPECT 32'h3f800000
`define SHADOW_REGS 16
`endif

// ==== rtl/fpa_pkg.sv ====
// Types shared by the float accelerator port and its bench.
// Assumes fpa_map.svh supplies all numeric constants.
package fpa_pkg;
	typedef logic [3:0] opcode_type;
	// Unpacked number: signed exponent with bias, mantissa with hidden bit at 55.
	typedef struct packed {
		logic sign;
		logic [9:0] exp;
		logic [56:0] man;
	} unpacked_type;
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} cond_type;
	typedef struct packed {
		logic fromShadow;
		logic [3:0] regIndex;
	} operand_src_type;
endpackage

// ==== rtl/float_accel_host_interface.sv ====
// Float accelerator host port: operand intake, microsequenced arithmetic, result return.
// Assumes the host logic runs on core_clk and keeps its side of both handshakes.
`timescale 1ns/1ps
`include "fpa_map.svh"

module float_accel_host_interface (
	input wire logic core_clk, // Core clock, 250 MHz.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic hostPhaseZero, // Host phase-zero pulse.
	output logic accelPhaseZero, // Our phase-zero marker.
	input wire fpa_pkg::opcode_type opcode, // Opcode from instruction buffer.
	input wire logic opcodeValid, // Opcode strobe.
	input wire logic hostSync, // Host sync level.
	output logic accelSync, // Accelerator sync level.
	input wire logic [31:0] instrDataBus, // Operand word.
	input wire fpa_pkg::operand_src_type operandSrc, // Shadow register operand select.
	input wire logic [31:0] resultBusIn, // Return bus as driven by host.
	output logic [31:0] resultBusOut, // Return bus drive value.
	output logic resultBusOe, // Return bus drive enable.
	input wire logic regUpdateValid, // Host register update strobe.
	input wire logic [3:0] regUpdateIndex, // Updated register number.
	output fpa_pkg::cond_type condCodes, // Condition codes of result.
	output logic accelFaultOut, // Internal error level.
	input wire logic diagTrapRequest, // Diagnostic trap request.
	input wire logic trapEntrySelect, // 0 power-up trap, 1 abort trap.
	output logic busy // Operation in progress.
);
	typedef enum logic [3:0] {
		S_IDLE, S_OPERAND, S_ARITH, S_DIVIDE, S_NORM, S_FRACT, S_SEND, S_FAULT
	} state_type;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	function automatic logic isDouble(input fpa_pkg::opcode_type op);
		isDouble = op[0];
	endfunction

	// Splits a packed word pair and restores the hidden bit.
	function automatic fpa_pkg::unpacked_type unpackWord(input logic [63:0] w, input logic dbl);
		fpa_pkg::unpacked_type u;
		u.sign = w[`SIGN_BIT];
		u.exp = {2'b00, w[`EXP_MSB:`EXP_LSB]};
		u.man = {2'b01, w[54:0]};
		if (!dbl) begin
			u.man[31:0] = 32'h0;
		end
		if (w[`EXP_MSB:`EXP_LSB] == 8'h00) begin
			u = '0;
		end
		unpackWord = u;
	endfunction

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMetaQ;
	logic rstN;

	// Release is synchronised so every flop leaves reset on the same edge.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMetaQ <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMetaQ <= 1'b1;
			rstN <= rstMetaQ;
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_type stateQ, stateD;
	fpa_pkg::opcode_type opQ, opD;
	fpa_pkg::unpacked_type aQ, aD, bQ, bD, xQ, xD, workQ, workD;
	fpa_pkg::cond_type ccQ, ccD;
	logic [1:0] numQ, numD;
	logic wordHiQ, wordHiD, polyAddQ, polyAddD, diagQ, diagD, ackQ, ackD;
	logic sendLeftQ, sendLeftD, faultPendQ, faultPendD, faultQ, faultD, trapPrevQ;
	// Set once the last operand handshake has closed and the result is on offer.
	logic offerQ, offerD;
	logic [31:0] bufQ, bufD, intAQ, intAD;
	logic [7:0] coefLeftQ, coefLeftD;
	logic [63:0] resQ, resD;
	logic [56:0] remQ, remD;
	logic [5:0] divCntQ, divCntD, phaseQ, phaseD;
	logic [31:0] shadowQ [`SHADOW_REGS];
	logic [31:0] shadowD [`SHADOW_REGS];
	logic take, done, fault, trapEdge, aBig;
	logic [2:0] cls, aluCls;
	logic [31:0] operandWord;
	logic [63:0] fullWord, intProd;
	logic [111:0] prod;
	logic [9:0] sh;
	logic [56:0] smallMan;
	fpa_pkg::unpacked_type up, bb, big, lesser, mb, fin;

	// ----------------------------------------------------------------
	// Shadow register copy
	// ----------------------------------------------------------------
	// Power-up trap clears the copy; otherwise host updates arrive on the return bus.
	always_comb begin
		shadowD = shadowQ;
		if (trapEdge && !trapEntrySelect) begin
			for (int i = 0; i < `SHADOW_REGS; i++) begin
				shadowD[i] = 32'h0;
			end
		end else if (regUpdateValid) begin
			shadowD[regUpdateIndex] = resultBusIn;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			for (int i = 0; i < `SHADOW_REGS; i++) begin
				shadowQ[i] <= 32'h0;
			end
		end else begin
			shadowQ <= shadowD;
		end
	end

	// ----------------------------------------------------------------
	// Microsequencer
	// ----------------------------------------------------------------
	assign cls = opQ[3:1];
	assign take = hostSync && !ackQ;
	assign trapEdge = diagTrapRequest && !trapPrevQ;

	// One process computes every next value but the shadow copy's and trapPrevQ's; arithmetic is shared by all classes but integer multiply.
	always_comb begin
		stateD = stateQ;
		opD = opQ;
		aD = aQ;
		bD = bQ;
		xD = xQ;
		workD = workQ;
		ccD = ccQ;
		numD = numQ;
		wordHiD = wordHiQ;
		polyAddD = polyAddQ;
		diagD = diagQ;
		ackD = ackQ;
		sendLeftD = sendLeftQ;
		faultPendD = faultPendQ;
		faultD = faultQ;
		bufD = bufQ;
		intAD = intAQ;
		coefLeftD = coefLeftQ;
		resD = resQ;
		remD = remQ;
		divCntD = divCntQ;
		done = 1'b0;
		fault = 1'b0;
		fin = workQ;
		phaseD = (phaseQ == 6'(`MICROCYCLE_CYCLES - 1)) ? 6'h00 : phaseQ + 6'h01;
		if (hostPhaseZero) begin
			phaseD = 6'h01;
		end
		operandWord = operandSrc.fromShadow ? shadowQ[operandSrc.regIndex] : instrDataBus;
		fullWord = wordHiQ ? {bufQ, operandWord} : {operandWord, 32'h0};
		up = unpackWord(fullWord, isDouble(opQ));
		// Both factors are widened first so the high word survives for the overflow flag.
		intProd = $signed({{32{intAQ[31]}}, intAQ})
			* $signed({{32{operandWord[31]}}, operandWord});
		aluCls = (cls == `CLS_POLY) ? (polyAddQ ? `CLS_ADD : `CLS_MUL) : cls;
		bb = bQ;
		if (aluCls == `CLS_SUB) begin
			bb.sign = !bQ.sign;
		end
		aBig = {aQ.exp, aQ.man} >= {bb.exp, bb.man};
		big = aBig ? aQ : bb;
		lesser = aBig ? bb : aQ;
		sh = big.exp - lesser.exp;
		smallMan = (sh > 10'd56) ? 57'h0 : lesser.man >> sh;
		mb = (cls == `CLS_POLY) ? xQ : bQ;
		prod = aQ.man[55:0] * mb.man[55:0];
		// Host drops its sync before a new transfer is taken.
		if (!hostSync) begin
			ackD = 1'b0;
		end
		case (stateQ)
			S_IDLE: begin
				if (opcodeValid) begin
					opD = opcode;
					numD = 2'd0;
					wordHiD = 1'b0;
					polyAddD = 1'b0;
					diagD = 1'b0;
					stateD = S_OPERAND;
					fault = (opcode > `OP_INT_MUL);
				end
			end
			S_OPERAND: begin
				if (take) begin
					ackD = 1'b1;
					if (isDouble(opQ) && !wordHiQ && !(cls == `CLS_POLY && numQ == 2'd1)) begin
						bufD = operandWord;
						wordHiD = 1'b1;
					end else begin
						wordHiD = 1'b0;
						numD = (numQ == 2'd3) ? 2'd3 : numQ + 2'd1;
						if (cls == `CLS_INT_MUL) begin
							intAD = operandWord;
							if (numQ != 2'd0) begin
								resD = {intProd[31:0], 32'h0};
								ccD = {intProd[31], intProd[31:0] == 32'h0,
									intProd[63:32] != {32{intProd[31]}}, 1'b0};
								sendLeftD = 1'b0;
								stateD = S_SEND;
							end
						end else if (cls == `CLS_POLY) begin
							case (numQ)
								2'd0: xD = up;
								2'd1: coefLeftD = operandWord[7:0];
								2'd2: begin
									aD = up;
									if (coefLeftQ == 8'h00) begin
										workD = up;
										polyAddD = 1'b1;
										stateD = S_NORM;
									end
								end
								default: begin
									bD = up;
									coefLeftD = coefLeftQ - 8'h01;
									stateD = S_ARITH;
								end
							endcase
						end else if (numQ == 2'd0) begin
							aD = up;
						end else begin
							bD = up;
							stateD = S_ARITH;
						end
					end
				end
			end
			S_ARITH: begin
				stateD = S_NORM;
				case (aluCls)
					`CLS_ADD, `CLS_SUB: begin
						workD.sign = big.sign;
						workD.exp = big.exp;
						workD.man = (big.sign == lesser.sign) ? big.man + smallMan : big.man - smallMan;
					end
					`CLS_DIV: begin
						workD.sign = aQ.sign ^ bQ.sign;
						workD.exp = aQ.exp - bQ.exp + `EXP_BIAS;
						workD.man = 57'h0;
						remD = aQ.man;
						divCntD = 6'd56;
						stateD = S_DIVIDE;
						fault = (bQ.man == 57'h0);
					end
					default: begin
						workD.sign = aQ.sign ^ mb.sign;
						workD.exp = aQ.exp + mb.exp - `EXP_BIAS;
						// Two fractions below one: the product's point sits 56 places down.
						workD.man = 57'(prod >> 56);
					end
				endcase
			end
			S_DIVIDE: begin
				// Restoring division, one quotient bit per clock, integer bit first.
				workD.man = {workQ.man[55:0], remQ >= bQ.man};
				remD = (remQ >= bQ.man) ? (remQ - bQ.man) << 1 : remQ << 1;
				divCntD = divCntQ - 6'd1;
				if (divCntQ == 6'd0) begin
					stateD = S_NORM;
				end
			end
			S_NORM: begin
				if (workQ.man == 57'h0) begin
					fin = '0;
					done = 1'b1;
				end else if (workQ.man[56]) begin
					workD.man = workQ.man >> 1;
					workD.exp = workQ.exp + 10'd1;
				end else if (!workQ.man[55]) begin
					workD.man = workQ.man << 1;
					workD.exp = workQ.exp - 10'd1;
				end else if ($signed(workQ.exp) > $signed(`EXP_MAX)) begin
					fault = 1'b1;
				end else begin
					// Underflow flushes to zero rather than trapping.
					if ($signed(workQ.exp) < $signed(`EXP_MIN)) begin
						fin = '0;
					end
					done = 1'b1;
				end
			end
			S_FRACT: begin
				// Drops integer bits one at a time; the integer part is not returned.
				if ($signed(workQ.exp) > $signed(`EXP_BIAS)) begin
					workD.man = {1'b0, workQ.man[54:0], 1'b0};
					workD.exp = workQ.exp - 10'd1;
				end else begin
					stateD = S_NORM;
				end
			end
			S_SEND: begin
				if (take && offerQ) begin
					ackD = 1'b1;
					resD = {resQ[31:0], 32'h0};
					sendLeftD = 1'b0;
					if (!sendLeftQ) begin
						stateD = S_IDLE;
					end
				end
			end
			S_FAULT: begin
				stateD = S_FAULT;
			end
			default: stateD = S_IDLE;
		endcase
		// Finished value: extended modulus, polynomial step, or pack.
		if (done) begin
			if (cls == `CLS_EMOD && $signed(fin.exp) > $signed(`EXP_BIAS)) begin
				stateD = S_FRACT;
			end else if (cls == `CLS_POLY && !polyAddQ) begin
				aD = fin;
				polyAddD = 1'b1;
				stateD = S_ARITH;
			end else if (cls == `CLS_POLY && coefLeftQ != 8'h00) begin
				aD = fin;
				polyAddD = 1'b0;
				stateD = S_OPERAND;
			end else begin
				resD = {fin.sign, fin.exp[7:0], fin.man[54:0]};
				ccD = {fin.sign, fin.man == 57'h0, 1'b0, 1'b0};
				sendLeftD = isDouble(opQ);
				stateD = S_SEND;
				if (diagQ) begin
					fault = (resD[63:32] != `DIAG_EXPECT);
					stateD = S_IDLE;
				end
			end
		end
		if (fault) begin
			faultPendD = 1'b1;
			stateD = S_FAULT;
		end
		if (faultPendQ && phaseQ == 6'h00) begin
			faultD = 1'b1;
		end
		if (trapEdge) begin
			faultPendD = 1'b0;
			faultD = 1'b0;
			stateD = S_IDLE;
			if (!trapEntrySelect) begin
				aD = unpackWord(`DIAG_OPERAND, 1'b0);
				bD = aD;
				opD = `OP_MUL_SINGLE;
				diagD = 1'b1;
				stateD = S_ARITH;
			end
		end
		// The offer waits for the operand ack to close, so one sync never means both.
		offerD = (stateD == S_SEND) && (offerQ || (!ackQ && !ackD));
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			stateQ <= S_IDLE;
			opQ <= 4'h0;
			aQ <= '0;
			bQ <= '0;
			xQ <= '0;
			workQ <= '0;
			ccQ <= '0;
			numQ <= 2'd0;
			wordHiQ <= 1'b0;
			polyAddQ <= 1'b0;
			diagQ <= 1'b0;
			ackQ <= 1'b0;
			sendLeftQ <= 1'b0;
			faultPendQ <= 1'b0;
			faultQ <= 1'b0;
			trapPrevQ <= 1'b0;
			offerQ <= 1'b0;
			bufQ <= 32'h0;
			intAQ <= 32'h0;
			coefLeftQ <= 8'h00;
			resQ <= 64'h0;
			remQ <= 57'h0;
			divCntQ <= 6'h00;
			phaseQ <= 6'h00;
		end else begin
			stateQ <= stateD;
			opQ <= opD;
			aQ <= aD;
			bQ <= bD;
			xQ <= xD;
			workQ <= workD;
			ccQ <= ccD;
			numQ <= numD;
			wordHiQ <= wordHiD;
			polyAddQ <= polyAddD;
			diagQ <= diagD;
			ackQ <= ackD;
			sendLeftQ <= sendLeftD;
			faultPendQ <= faultPendD;
			faultQ <= faultD;
			trapPrevQ <= diagTrapRequest;
			offerQ <= offerD;
			bufQ <= bufD;
			intAQ <= intAD;
			coefLeftQ <= coefLeftD;
			resQ <= resD;
			remQ <= remD;
			divCntQ <= divCntD;
			phaseQ <= phaseD;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Sync held until the other side answers.
	// Idle shows no sync, so a taken last word is not mistaken for a fresh ack.
	assign accelSync = (stateQ == S_SEND && offerQ) ? !ackQ : (stateQ != S_IDLE) && ackQ;
	assign resultBusOut = resQ[63:32];
	assign resultBusOe = (stateQ == S_SEND) && offerQ;
	assign condCodes = ccQ;
	assign accelFaultOut = faultQ;
	assign accelPhaseZero = (phaseQ == 6'h00);
	assign busy = (stateQ != S_IDLE);
endmodule

// ==== tb/float_accel_checker_assertions.sv ====
// Concurrent checks on the float accelerator host port.
// Assumes it is bound to float_accel_host_interface and sees its ports only.
`timescale 1ns/1ps
`include "fpa_map.svh"
module float_accel_checker (
	input wire logic core_clk, // Clock.
	input wire logic arst_n, // Reset, active low.
	input wire logic hostPhaseZero, // Host phase zero.
	input wire logic accelPhaseZero, // Our phase zero.
	input wire fpa_pkg::opcode_type opcode, // Opcode.
	input wire logic opcodeValid, // Opcode strobe.
	input wire logic hostSync, // Host sync.
	input wire logic accelSync, // Our sync.
	input wire logic [31:0] resultBusOut, // Result word.
	input wire logic resultBusOe, // Result drive.
	input wire fpa_pkg::cond_type condCodes, // Flags.
	input wire logic accelFaultOut, // Fault.
	input wire logic diagTrapRequest, // Trap request.
	input wire logic trapEntrySelect, // Trap select.
	input wire logic busy // Busy.
);
	// ----------
	// Reset copy
	// ----------
	logic [1:0] rstQ;
	logic [1:0] rstD;
	// Checks wait for the same two-flop release that the design sees.
	always_comb begin
		rstD = {rstQ[0], 1'b1};
	end
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstQ <= 2'h0;
		end else begin
			rstQ <= rstD;
		end
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstQ[1]);
	// ------
	// Checks
	// ------
	sequence opndOffer;
		$rose(hostSync) && busy && !resultBusOe;
	endsequence
	sequence resTaken;
		resultBusOe && accelSync && hostSync;
	endsequence
	sequence trapEdge;
		$rose(diagTrapRequest);
	endsequence
	phase_align_a: assert property (hostPhaseZero |-> ##50 accelPhaseZero)
		else $error("phase zero lost alignment");
	op_start_a: assert property (opcodeValid && !busy && opcode <= `OP_INT_MUL |=> busy)
		else $error("opcode not taken when idle");
	opnd_ack_a: assert property (opndOffer |=> accelSync)
		else $error("operand not acknowledged");
	opnd_hold_a: assert property (accelSync && hostSync && !resultBusOe |=> accelSync)
		else $error("operand ack dropped early");
	opnd_drop_a: assert property (accelSync && !hostSync && !resultBusOe |=>
		!accelSync || resultBusOe)
		else $error("operand ack held too long");
	res_show_a: assert property ($rose(resultBusOe) |-> accelSync)
		else $error("result shown without sync");
	res_ack_a: assert property (resTaken |=> !accelSync)
		else $error("result sync kept after take");
	res_stand_a: assert property (resultBusOe && accelSync && !hostSync |=>
		resultBusOe && $stable(resultBusOut) && $stable(condCodes))
		else $error("result or flags moved before take");
	idle_quiet_a: assert property (!busy |-> !resultBusOe)
		else $error("result driven while idle");
	fault_align_a: assert property ($rose(accelFaultOut) |->
		accelPhaseZero || $past(accelPhaseZero))
		else $error("fault not on phase zero");
	trap_clear_a: assert property (trapEdge |-> ##[1:3] !accelFaultOut)
		else $error("trap left fault set");
	trap_abort_a: assert property (trapEdge ##0 trapEntrySelect |->
		##[1:3] (!busy && !resultBusOe))
		else $error("abort trap did not stop work");
endmodule
bind float_accel_host_interface float_accel_checker chk_u (
	.core_clk(core_clk), .arst_n(arst_n), .hostPhaseZero(hostPhaseZero),
	.accelPhaseZero(accelPhaseZero), .opcode(opcode), .opcodeValid(opcodeValid),
	.hostSync(hostSync), .accelSync(accelSync), .resultBusOut(resultBusOut),
	.resultBusOe(resultBusOe), .condCodes(condCodes), .accelFaultOut(accelFaultOut),
	.diagTrapRequest(diagTrapRequest), .trapEntrySelect(trapEntrySelect), .busy(busy)
);

// ==== tb/host_model.sv ====
// Behavioural host side of the operand and result sync handshakes.
// Assumes a shared core_clk and that the bench calls one task at a time.
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk, // Shared clock.
	input wire logic accelSync, // Accelerator sync.
	input wire logic [31:0] resultBusOut, // Result word.
	input wire fpa_pkg::cond_type condCodes, // Result flags.
	output logic hostSync, // Host sync.
	output logic [31:0] instrDataBus // Operand word.
);
	initial begin
		hostSync = 1'b0;
		instrDataBus = 32'h0;
	end
	// ---------------
	// Handshake tasks
	// ---------------
	// Waits at most n+1 edges for accelSync to reach v; ok drops on a hang.
	task automatic waitAck(input logic v, input int n, inout logic ok);
		int k;
		k = 0;
		@(posedge core_clk);
		while (accelSync !== v && k < n) begin
			k++;
			@(posedge core_clk);
		end
		if (accelSync !== v) ok = 1'b0;
	endtask
	task automatic sendWord(input logic [31:0] w, input int lag, inout logic ok);
		repeat (lag) @(posedge core_clk);
		@(posedge core_clk);
		#1;
		hostSync = 1'b1;
		instrDataBus = w;
		waitAck(1'b1, 50, ok);
		#1;
		hostSync = 1'b0;
		// A released bus shows the inverse, so a late capture cannot pass.
		instrDataBus = ~w;
		waitAck(1'b0, 50, ok);
	endtask
	// Result and flags taken where they stand.
	task automatic takeWord(input int lag, output logic [31:0] w,
		output fpa_pkg::cond_type cc, inout logic ok);
		waitAck(1'b1, 300, ok);
		w = resultBusOut;
		cc = condCodes;
		repeat (lag) @(posedge core_clk);
		#1;
		hostSync = 1'b1;
		waitAck(1'b0, 50, ok);
		#1;
		hostSync = 1'b0;
	endtask
endmodule

// ==== tb/tb_float_accel_host_interface.sv ====
// Self-checking bench for the float accelerator host port.
// Assumes host_model plays the host side of both handshakes.
`timescale 1ns/1ps
`include "fpa_map.svh"
module tb_float_accel_host_interface;
	logic core_clk, arst_n, hostPhaseZero, opcodeValid, hostSync, accelPhaseZero;
	logic accelSync, resultBusOe, regUpdateValid, accelFaultOut, diagTrapRequest;
	logic trapEntrySelect, busy;
	logic [31:0] instrDataBus, resultBusIn, resultBusOut;
	logic [3:0] regUpdateIndex;
	fpa_pkg::opcode_type opcode;
	fpa_pkg::operand_src_type operandSrc;
	fpa_pkg::cond_type condCodes;
	int badCount, comparisons, cycleCount;
	// Per class: add, sub, mul, div, poly, emod, integer multiply.
	localparam logic [31:0] opA [7] = '{32'h40000000, 32'h40000000, 32'h40000000,
		32'h40000000, 32'h40000000, 32'h40c00000, 32'h00000003};
	localparam logic [31:0] opB [7] = '{32'h40000000, 32'h40800000, 32'h40000000,
		32'h40000000, 32'h40800000, 32'h40800000, 32'h00000005};
	localparam logic [31:0] opR [7] = '{32'h40800000, 32'hc0000000, 32'h3f800000,
		32'h40800000, 32'h40800000, 32'h40000000, 32'h0000000f};
	localparam logic [6:0] ccNeg = 7'h02;
	float_accel_host_interface dut_u (
		.core_clk(core_clk), .arst_n(arst_n), .hostPhaseZero(hostPhaseZero),
		.accelPhaseZero(accelPhaseZero), .opcode(opcode), .opcodeValid(opcodeValid),
		.hostSync(hostSync), .accelSync(accelSync), .instrDataBus(instrDataBus),
		.operandSrc(operandSrc), .resultBusIn(resultBusIn), .resultBusOut(resultBusOut),
		.resultBusOe(resultBusOe), .regUpdateValid(regUpdateValid),
		.regUpdateIndex(regUpdateIndex), .condCodes(condCodes),
		.accelFaultOut(accelFaultOut), .diagTrapRequest(diagTrapRequest),
		.trapEntrySelect(trapEntrySelect), .busy(busy)
	);
	host_model host_u (
		.core_clk(core_clk), .accelSync(accelSync), .resultBusOut(resultBusOut),
		.condCodes(condCodes), .hostSync(hostSync), .instrDataBus(instrDataBus)
	);
	// -----------------
	// Clock and pacing
	// -----------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Host phase zero, one pulse per 50 cycles.
	initial begin
		hostPhaseZero = 1'b0;
		forever begin
			repeat (49) @(posedge core_clk);
			#1;
			hostPhaseZero = 1'b1;
			@(posedge core_clk);
			#1;
			hostPhaseZero = 1'b0;
		end
	end
	// A hang is cut short well beyond the expected several hundred cycles.
	always @(posedge core_clk) begin
		cycleCount++;
		if (cycleCount == 20000) begin
			badCount++;
			wrapUp();
		end
	end
	// -----
	// Tasks
	// -----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrapUp();
		$display("Comparisons %0d, mismatches %0d", comparisons, badCount);
		if (badCount == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Opcodes are only offered once the port is idle.
	task automatic issue(input fpa_pkg::opcode_type op);
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 300) begin
			k++;
			@(posedge core_clk);
		end
		@(posedge core_clk);
		#1;
		opcode = op;
		opcodeValid = 1'b1;
		@(posedge core_clk);
		#1;
		opcodeValid = 1'b0;
	endtask
	// Every opcode, single then double, with host lags that vary.
	task automatic scOps();
		logic [31:0] w;
		fpa_pkg::cond_type cc;
		logic ok;
		int c;
		for (int i = 0; i < 13; i++) begin
			ok = 1'b1;
			c = i / 2;
			issue(4'(i));
			host_u.sendWord(opA[c], i % 3, ok);
			if (i[0]) host_u.sendWord(32'h0, 0, ok);
			if (c == 4) host_u.sendWord(32'h0, 0, ok);
			host_u.sendWord(opB[c], 0, ok);
			if (i[0]) host_u.sendWord(32'h0, 0, ok);
			host_u.takeWord(i % 4, w, cc, ok);
			check(w, opR[c]);
			check({cc.n, cc.z, cc.v}, {ccNeg[c], 2'h0});
			if (i[0]) begin
				host_u.takeWord(0, w, cc, ok);
				check(w, 32'h0);
			end
			check(ok, 1'b1);
		end
	endtask
	// Shadow register 3 plus one half; a busy opcode pulse must be ignored.
	task automatic shAdd(input logic [31:0] exp);
		logic [31:0] w;
		fpa_pkg::cond_type cc;
		logic ok;
		ok = 1'b1;
		issue(`OP_ADD_SINGLE);
		operandSrc = 5'h13;
		host_u.sendWord(32'h0, 0, ok);
		#1;
		operandSrc = 5'h00;
		opcode = `OP_MUL_SINGLE;
		opcodeValid = 1'b1;
		@(posedge core_clk);
		#1;
		opcodeValid = 1'b0;
		host_u.sendWord(32'h40000000, 0, ok);
		host_u.takeWord(0, w, cc, ok);
		check(w, exp);
		check(ok, 1'b1);
	endtask
	task automatic scShadow();
		@(posedge core_clk);
		#1;
		resultBusIn = 32'h40800000;
		regUpdateIndex = 4'h3;
		regUpdateValid = 1'b1;
		@(posedge core_clk);
		#1;
		regUpdateValid = 1'b0;
		resultBusIn = 32'hbf7fffff;
		shAdd(32'h40c00000);
	endtask
	task automatic waitFault();
		int k;
		k = 0;
		while (accelFaultOut !== 1'b1 && k < 150) begin
			k++;
			@(posedge core_clk);
		end
		#1;
		check(accelFaultOut, 1'b1);
	endtask
	task automatic trap(input logic sel);
		@(posedge core_clk);
		#1;
		trapEntrySelect = sel;
		diagTrapRequest = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		diagTrapRequest = 1'b0;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	// Divide by zero then abort; bad opcode then power-up, which empties the shadow.
	task automatic scFault();
		logic ok;
		ok = 1'b1;
		issue(`OP_DIV_SINGLE);
		host_u.sendWord(32'h40000000, 0, ok);
		host_u.sendWord(32'h0, 0, ok);
		waitFault();
		trap(1'b1);
		check({accelFaultOut, busy, resultBusOe}, 32'h0);
		issue(4'hd);
		waitFault();
		trap(1'b0);
		check(accelFaultOut, 1'b0);
		shAdd(32'h40000000);
		// A failed self-test only shows at the next phase zero, so wait a microcycle.
		repeat (50) @(posedge core_clk);
		#1;
		check(accelFaultOut, 1'b0);
	endtask
	// ---------
	// Sequence
	// ---------
	initial begin
		arst_n = 1'b0;
		opcode = 4'h0;
		opcodeValid = 1'b0;
		operandSrc = 5'h00;
		resultBusIn = 32'h0;
		regUpdateValid = 1'b0;
		regUpdateIndex = 4'h0;
		diagTrapRequest = 1'b0;
		trapEntrySelect = 1'b0;
		badCount = 0;
		comparisons = 0;
		cycleCount = 0;
		repeat (12) @(posedge core_clk);
		#1;
		check({accelPhaseZero, accelSync, resultBusOe, busy, accelFaultOut, condCodes},
			32'h100);
		arst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		scOps();
		scShadow();
		scFault();
		wrapUp();
	end
endmodule
